/* File: src/aau_pkg.sv */
// constants, field layout and types for the add/abs execution unit
// assumes the core decodes nothing for us: the raw 32-bit instruction word arrives
package aau_pkg;

  // ***********************************
  // instruction fields
  // ***********************************
  localparam int INSN_W = 32;
  localparam int OPC_W = 6;
  localparam int REG_W = 5;
  localparam int IMM_W = 16;
  localparam int F_OP_LO = 26;
  localparam int F_FMT_LO = 21;
  localparam int F_FT_LO = 16;
  localparam int F_FS_LO = 11;
  localparam int F_FD_LO = 6;
  localparam int F_FN_LO = 0;
  localparam logic [OPC_W-1:0] OP_FP = 6'h11;
  localparam logic [OPC_W-1:0] OP_SPECIAL = 6'h00;
  localparam logic [OPC_W-1:0] OP_TADDI = 6'h08;
  localparam logic [OPC_W-1:0] FN_ABS = 6'h05;
  localparam logic [OPC_W-1:0] FN_FADD = 6'h00;
  localparam logic [OPC_W-1:0] FN_TADD = 6'h20;
  localparam logic [REG_W-1:0] FIELD_ZERO = 5'h00;
  localparam logic [REG_W-1:0] FMT_S = 5'h10;
  localparam logic [REG_W-1:0] FMT_D = 5'h11;
  localparam logic [REG_W-1:0] FMT_PS = 5'h16;

  // ***********************************
  // data widths and float layouts
  // ***********************************
  localparam int WORD = 32;
  localparam int XLEN = 64;
  localparam int S_EW = 8;
  localparam int S_MW = 23;
  localparam int D_EW = 11;
  localparam int D_MW = 52;

  // ***********************************
  // control/status fields
  // ***********************************
  localparam int C_I = 0;
  localparam int C_U = 1;
  localparam int C_O = 2;
  localparam int C_Z = 3;
  localparam int C_V = 4;
  localparam int C_E = 5;
  localparam int FLAG_W = 5;
  localparam int CAUSE_W = 6;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h00;
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 6'h00;
  localparam logic [1:0] RM_RN = 2'h0;
  localparam logic [1:0] RM_RZ = 2'h1;
  localparam logic [1:0] RM_RP = 2'h2;
  localparam logic [1:0] RM_RM = 2'h3;

  typedef enum logic [2:0] {
    EXC_NONE = 3'h0,
    EXC_RI = 3'h1,
    EXC_CPU = 3'h2,
    EXC_OVF = 3'h3,
    EXC_FPE = 3'h4
  } aau_exc_t;

endpackage : aau_pkg

/* File: src/aau_lane_if.sv */
// one float lane's operands, controls and answer
// assumes the owner drives the operand side every cycle
interface aau_lane_if #(parameter int W = 32);
  logic [W-1:0] a;
  logic [W-1:0] b;
  logic is_abs;
  logic arith_abs;
  logic [1:0] rmode;
  logic [W-1:0] res;
  logic [5:0] cause;
  modport core (output a, output b, output is_abs, output arith_abs, output rmode,
    input res, input cause);
  modport lane (input a, input b, input is_abs, input arith_abs, input rmode,
    output res, output cause);
endinterface : aau_lane_if

/* File: src/aau_fp_lane.sv */
// combinational float lane: absolute value or add, one format
// assumes operands are in the lane's format; answer settles in the same cycle
module aau_fp_lane
  import aau_pkg::*;
#(
  parameter int EW = S_EW,
  parameter int MW = S_MW
) (
  aau_lane_if.lane lp
);
  localparam int W = 1 + EW + MW;
  localparam int SW = MW + 4;
  localparam logic [EW-1:0] EMAX = '1;
  localparam logic [EW-1:0] EMIN = 1;
  localparam logic [EW+1:0] E_ONE = 1;
  localparam logic [W-1:0] QNAN = {1'b0, EMAX, 1'b1, {(MW-1){1'b0}}};

  logic sa, sb, sr, nan_a, nan_b, snan, inf_a, inf_b, swap, stk, inx, up, tiny;
  logic [EW-1:0] ea, eb, eh, el;
  logic [MW-1:0] ma, mb, mh, ml;
  logic [SW:0] big, sml, sum;
  logic [EW:0] d;
  logic [EW+1:0] e;
  logic [MW+1:0] rnd;

  assign {sa, ea, ma} = lp.a;
  assign {sb, eb, mb} = lp.b;
  assign nan_a = (ea == EMAX) && (ma != '0);
  assign nan_b = (eb == EMAX) && (mb != '0);
  assign inf_a = (ea == EMAX) && (ma == '0);
  assign inf_b = (eb == EMAX) && (mb == '0);
  assign snan = (nan_a && !ma[MW-1]) || (nan_b && !mb[MW-1]);
  assign swap = {eb, mb} > {ea, ma};

  always_comb begin
    lp.res = '0;
    lp.cause = '0;
    {sr, eh, mh, el, ml} = '0;
    {big, sml, sum, d, e, rnd} = '0;
    {stk, inx, up, tiny} = '0;
    if (lp.is_abs) begin
      lp.res = {1'b0, lp.a[W-2:0]};
      // arithmetic form: any nan is invalid and yields the default nan
      if (lp.arith_abs && nan_a) begin
        lp.cause[C_V] = 1'b1;
        lp.res = QNAN;
      end
    end else if (nan_a || nan_b) begin
      lp.cause[C_V] = snan;
      lp.res = QNAN;
    end else if (inf_a || inf_b) begin
      if (inf_a && inf_b && (sa != sb)) begin
        lp.cause[C_V] = 1'b1;
        lp.res = QNAN;
      end else begin
        lp.res = inf_a ? lp.a : lp.b;
      end
    end else begin
      sr = swap ? sb : sa;
      {eh, mh} = swap ? {eb, mb} : {ea, ma};
      {el, ml} = swap ? {ea, ma} : {eb, mb};
      big = {1'b0, eh != '0, mh, 3'b000};
      sml = {1'b0, el != '0, ml, 3'b000};
      // denormals behave as exponent one
      d = {1'b0, (eh == '0) ? EMIN : eh} - {1'b0, (el == '0) ? EMIN : el};
      for (int i = 0; i < SW; i++) begin
        if (i < d) begin
          stk = stk | sml[0];
          sml = sml >> 1;
        end
      end
      sml[0] = sml[0] | stk;
      sum = (sa == sb) ? big + sml : big - sml;
      e = {2'b00, (eh == '0) ? EMIN : eh};
      if (sum == '0) begin
        lp.res = {(sa == sb) ? sa : (lp.rmode == RM_RM), {(W-1){1'b0}}};
      end else begin
        if (sum[SW]) begin
          sum = {1'b0, sum[SW:2], sum[1] | sum[0]};
          e = e + E_ONE;
        end
        for (int i = 0; i < SW; i++) begin
          if (!sum[SW-1] && (e > E_ONE)) begin
            sum = sum << 1;
            e = e - E_ONE;
          end
        end
        tiny = !sum[SW-1];
        inx = |sum[2:0];
        case (lp.rmode)
          RM_RN: up = sum[2] & (sum[1] | sum[0] | sum[3]);
          RM_RP: up = !sr & inx;
          RM_RM: up = sr & inx;
          default: up = 1'b0;
        endcase
        rnd = {1'b0, sum[SW-1:3]} + {{(MW+1){1'b0}}, up};
        if (rnd[MW+1]) begin
          rnd = rnd >> 1;
          e = e + E_ONE;
        end
        if (e >= {2'b00, EMAX}) begin
          inx = 1'b1;
          lp.cause[C_O] = 1'b1;
          if ((lp.rmode == RM_RZ) || (lp.rmode == (sr ? RM_RP : RM_RM))) begin
            lp.res = {sr, EMAX - EMIN, {MW{1'b1}}};
          end else begin
            lp.res = {sr, EMAX, {MW{1'b0}}};
          end
        end else begin
          lp.res = {sr, rnd[MW] ? e[EW-1:0] : {EW{1'b0}}, rnd[MW-1:0]};
        end
        lp.cause[C_I] = inx;
        lp.cause[C_U] = tiny & inx;
      end
    end
  end

endmodule : aau_fp_lane

/* File: src/aau_trap_add.sv */
// 32-bit signed add with overflow detect
// assumes operands are already reduced to their low words
module aau_trap_add
  import aau_pkg::*;
(
  input wire logic [WORD-1:0] opa,
  input wire logic [WORD-1:0] opb,
  output logic [WORD-1:0] sum,
  output logic ovf
);
  logic [WORD:0] wide;

  // duplicated sign bit: sum bit 32 disagrees with sum bit 31 on overflow
  assign wide = {opa[WORD-1], opa} + {opb[WORD-1], opb};
  assign ovf = wide[WORD] != wide[WORD-1];
  assign sum = wide[WORD-1:0];

endmodule : aau_trap_add

/* File: src/aau_unit.sv */
// add/abs execution unit: float abs, float add, trapping word and immediate add
// assumes the issue stage holds operands valid with issue_valid for one cycle
module aau_unit
  import aau_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic issue_valid,
  input wire logic [INSN_W-1:0] instr,
  input wire logic [XLEN-1:0] fp_source_a,
  input wire logic [XLEN-1:0] fp_source_b,
  input wire logic [XLEN-1:0] source_reg_a,
  input wire logic [XLEN-1:0] source_reg_b,
  input wire logic fpu_usable,
  input wire logic fpu_is_64bit,
  input wire logic fp_reg_model_bit,
  input wire logic release6_cfg,
  input wire logic magnitude2008_capable,
  input wire logic nonarith_magnitude_bit,
  input wire logic [1:0] fp_round_mode,
  input wire logic [FLAG_W-1:0] fp_trap_enable,
  output logic done,
  output aau_exc_t exc_code,
  output logic fpr_we,
  output logic gpr_we,
  output logic [REG_W-1:0] dest_idx,
  output logic [XLEN-1:0] result,
  output logic [CAUSE_W-1:0] fp_cause,
  output logic [FLAG_W-1:0] fp_flags
);

  // ***********************************
  // decode
  // ***********************************
  logic [OPC_W-1:0] f_op, f_fn;
  logic [REG_W-1:0] f_fmt, f_ft, f_fs, f_fd;
  logic [IMM_W-1:0] f_imm;
  logic is_abs, is_fadd, is_fp, is_wadd, is_iadd, is_int, fire;
  logic fmt_ok, is_ps, ps_ok, arith_abs, nonarith_abs;

  assign f_op = instr[F_OP_LO +: OPC_W];
  assign f_fmt = instr[F_FMT_LO +: REG_W];
  assign f_ft = instr[F_FT_LO +: REG_W];
  assign f_fs = instr[F_FS_LO +: REG_W];
  assign f_fd = instr[F_FD_LO +: REG_W];
  assign f_fn = instr[F_FN_LO +: OPC_W];
  assign f_imm = instr[IMM_W-1:0];

  assign is_abs = (f_op == OP_FP) && (f_fn == FN_ABS) && (f_ft == FIELD_ZERO);
  assign is_fadd = (f_op == OP_FP) && (f_fn == FN_FADD);
  assign is_fp = is_abs || is_fadd;
  assign is_wadd = (f_op == OP_SPECIAL) && (f_fn == FN_TADD) && (f_fd == FIELD_ZERO);
  assign is_iadd = (f_op == OP_TADDI);
  assign is_int = is_wadd || is_iadd;
  assign fire = clk_en && issue_valid;

  assign is_ps = (f_fmt == FMT_PS);
  assign fmt_ok = (f_fmt == FMT_S) || (f_fmt == FMT_D) || is_ps;
  // paired forms: pre-sixth-release only, and only where they are defined
  assign ps_ok = !release6_cfg && fpu_is_64bit && fp_reg_model_bit;
  assign arith_abs = !magnitude2008_capable || !nonarith_magnitude_bit;
  assign nonarith_abs = is_abs && !arith_abs;

  // ***********************************
  // float lanes
  // ***********************************
  aau_lane_if #(.W(XLEN)) d_if ();
  aau_lane_if #(.W(WORD)) lo_if ();
  aau_lane_if #(.W(WORD)) hi_if ();

  assign d_if.a = fp_source_a;
  assign d_if.b = fp_source_b;
  assign lo_if.a = fp_source_a[WORD-1:0];
  assign lo_if.b = fp_source_b[WORD-1:0];
  assign hi_if.a = fp_source_a[XLEN-1:WORD];
  assign hi_if.b = fp_source_b[XLEN-1:WORD];
  assign {d_if.is_abs, lo_if.is_abs, hi_if.is_abs} = {3{is_abs}};
  assign {d_if.arith_abs, lo_if.arith_abs, hi_if.arith_abs} = {3{arith_abs}};
  // rounding mode from the control/status register feeds every lane
  assign d_if.rmode = fp_round_mode;
  assign lo_if.rmode = fp_round_mode;
  assign hi_if.rmode = fp_round_mode;

  aau_fp_lane #(.EW(D_EW), .MW(D_MW)) u_lane_d (.lp(d_if.lane));
  aau_fp_lane #(.EW(S_EW), .MW(S_MW)) u_lane_lo (.lp(lo_if.lane));
  aau_fp_lane #(.EW(S_EW), .MW(S_MW)) u_lane_hi (.lp(hi_if.lane));

  logic [XLEN-1:0] fp_res;
  logic [CAUSE_W-1:0] fp_cause_raw, fp_cause_now;
  logic fp_taken;

  always_comb begin
    if (f_fmt == FMT_D) begin
      fp_res = d_if.res;
      fp_cause_raw = d_if.cause;
    end else if (is_ps) begin
      // halves computed apart; their conditions merge
      fp_res = {hi_if.res, lo_if.res};
      fp_cause_raw = hi_if.cause | lo_if.cause;
    end else begin
      fp_res = {{WORD{1'b0}}, lo_if.res};
      fp_cause_raw = lo_if.cause;
    end
  end

  // abs may only report invalid/unimplemented; add keeps all six
  always_comb begin
    fp_cause_now = fp_cause_raw;
    if (is_abs) begin
      fp_cause_now = '0;
      fp_cause_now[C_V] = fp_cause_raw[C_V];
      fp_cause_now[C_E] = fp_cause_raw[C_E];
    end
  end

  // unimplemented always traps; others only where enabled
  assign fp_taken = fp_cause_now[C_E] || ((fp_cause_now[C_V:C_I] & fp_trap_enable) != '0);

  // ***********************************
  // integer trapping adds
  // ***********************************
  logic [WORD-1:0] int_b, int_sum;
  logic int_ovf;
  logic [XLEN-1:0] int_res;

  assign int_b = is_iadd ? {{(WORD-IMM_W){f_imm[IMM_W-1]}}, f_imm}
                         : source_reg_b[WORD-1:0];

  // upper source bits are ignored: software keeps them as sign copies
  aau_trap_add u_trap_add (
    .opa(source_reg_a[WORD-1:0]),
    .opb(int_b),
    .sum(int_sum),
    .ovf(int_ovf)
  );

  assign int_res = {{(XLEN-WORD){int_sum[WORD-1]}}, int_sum};

  // ***********************************
  // outcome selection
  // ***********************************
  aau_exc_t nxt_exc;

  always_comb begin
    nxt_exc = EXC_NONE;
    if (is_fp) begin
      if (!fpu_usable) begin
        nxt_exc = EXC_CPU;
      end else if (!fmt_ok || (is_ps && !ps_ok)) begin
        nxt_exc = EXC_RI;
      end else if (fp_taken && !nonarith_abs) begin
        nxt_exc = EXC_FPE;
      end
    end else if (is_int) begin
      if (int_ovf) begin
        nxt_exc = EXC_OVF;
      end
    end else begin
      // anything else sent here is not ours to execute
      nxt_exc = EXC_RI;
    end
  end

  // ***********************************
  // result stage
  // ***********************************
  logic done_ff, fpr_we_ff, gpr_we_ff;
  aau_exc_t exc_ff;
  logic [REG_W-1:0] dest_idx_ff;
  logic [XLEN-1:0] result_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      done_ff <= 1'b0;
      exc_ff <= EXC_NONE;
      fpr_we_ff <= 1'b0;
      gpr_we_ff <= 1'b0;
    end else if (clk_en) begin
      done_ff <= issue_valid;
      exc_ff <= issue_valid ? nxt_exc : EXC_NONE;
      // no write on any exception keeps the destination untouched
      fpr_we_ff <= issue_valid && is_fp && (nxt_exc == EXC_NONE);
      gpr_we_ff <= issue_valid && is_int && (nxt_exc == EXC_NONE);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dest_idx_ff <= FIELD_ZERO;
      result_ff <= '0;
    end else if (fire) begin
      dest_idx_ff <= is_fp ? f_fd : (is_iadd ? f_ft : f_fd[REG_W-1:0]);
      if (is_wadd) begin
        dest_idx_ff <= instr[F_FS_LO +: REG_W];
      end
      result_ff <= is_fp ? fp_res : int_res;
    end
  end

  // ***********************************
  // cause and sticky flags
  // ***********************************
  logic [CAUSE_W-1:0] cause_ff;
  logic [FLAG_W-1:0] flags_ff;
  logic fp_counts;

  // non-arithmetic abs and instruction-level faults leave both fields alone
  assign fp_counts = fire && is_fp && fmt_ok && fpu_usable && !(is_ps && !ps_ok)
                     && !nonarith_abs;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cause_ff <= CAUSE_RST;
    end else if (fp_counts) begin
      cause_ff <= fp_cause_now;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags_ff <= FLAGS_RST;
    end else if (fp_counts && !fp_taken) begin
      flags_ff <= flags_ff | fp_cause_now[FLAG_W-1:0];
    end
  end

  assign done = done_ff;
  assign exc_code = exc_ff;
  assign fpr_we = fpr_we_ff;
  assign gpr_we = gpr_we_ff;
  assign dest_idx = dest_idx_ff;
  assign result = result_ff;
  assign fp_cause = cause_ff;
  assign fp_flags = flags_ff;

  // ***********************************
  // checks
  // ***********************************
  logic [XLEN-1:0] abs_clear_d;
  assign abs_clear_d = {1'b0, fp_source_a[XLEN-2:0]};

  property p_ovf_trap;
    @(posedge clk_sys) disable iff (rst)
    fire && is_int && int_ovf |=> exc_code == EXC_OVF && !gpr_we;
  endproperty
  a_ovf_trap: assert property (p_ovf_trap) else $error("overflow not trapped");

  property p_word_sext;
    @(posedge clk_sys) disable iff (rst)
    fire && is_wadd && !int_ovf |=> gpr_we && result == $past(int_res)
      && result[XLEN-1:WORD-1] == {(XLEN-WORD+1){result[WORD-1]}};
  endproperty
  a_word_sext: assert property (p_word_sext) else $error("word sum not extended");

  property p_imm_dest;
    @(posedge clk_sys) disable iff (rst)
    fire && is_iadd && !int_ovf |=> gpr_we && dest_idx == $past(f_ft);
  endproperty
  a_imm_dest: assert property (p_imm_dest) else $error("immediate dest wrong");

  property p_cpu_unusable;
    @(posedge clk_sys) disable iff (rst)
    fire && is_fp && !fpu_usable |=> exc_code == EXC_CPU && !fpr_we && $stable(fp_flags);
  endproperty
  a_cpu_unusable: assert property (p_cpu_unusable) else $error("no cop unusable");

  property p_ps_r6;
    @(posedge clk_sys) disable iff (rst)
    fire && is_fp && fpu_usable && is_ps && release6_cfg |=> exc_code == EXC_RI;
  endproperty
  a_ps_r6: assert property (p_ps_r6) else $error("paired form accepted");

  property p_nonarith;
    @(posedge clk_sys) disable iff (rst)
    fire && nonarith_abs && fpu_usable && fmt_ok && !is_ps |=>
      $stable(fp_flags) && $stable(fp_cause) && exc_code == EXC_NONE;
  endproperty
  a_nonarith: assert property (p_nonarith) else $error("status touched");

  property p_abs_sign;
    @(posedge clk_sys) disable iff (rst)
    fire && nonarith_abs && fpu_usable && f_fmt == FMT_D |=>
      fpr_we && result == $past(abs_clear_d);
  endproperty
  a_abs_sign: assert property (p_abs_sign) else $error("abs result wrong");

  property p_flags_or;
    @(posedge clk_sys) disable iff (rst)
    fp_counts && !fp_taken |=> fp_flags == ($past(fp_flags) | fp_cause[FLAG_W-1:0]);
  endproperty
  a_flags_or: assert property (p_flags_or) else $error("flags not accumulated");

  property p_abs_cause;
    @(posedge clk_sys) disable iff (rst)
    fp_counts && is_abs |=> fp_cause[C_I] == 1'b0 && fp_cause[C_U] == 1'b0
      && fp_cause[C_O] == 1'b0 && fp_cause[C_Z] == 1'b0;
  endproperty
  a_abs_cause: assert property (p_abs_cause) else $error("abs cause illegal");

  c_ovf: cover property (@(posedge clk_sys) disable iff (rst) exc_code == EXC_OVF);
  c_ps_add: cover property (@(posedge clk_sys) disable iff (rst)
    fire && is_fadd && is_ps && ps_ok ##1 fpr_we);
  c_fpe: cover property (@(posedge clk_sys) disable iff (rst) exc_code == EXC_FPE);

endmodule : aau_unit

/* File: testbench/aau_core_model.sv */
// issue-stage model: puts one instruction and its operands on the unit's inputs
// assumes the unit samples the issue on the rising clk_sys edge
module aau_core_model
  import aau_pkg::*;
(
  input wire logic clk_sys,
  output logic issue_valid,
  output logic [INSN_W-1:0] instr,
  output logic [XLEN-1:0] fp_source_a,
  output logic [XLEN-1:0] fp_source_b,
  output logic [XLEN-1:0] source_reg_a,
  output logic [XLEN-1:0] source_reg_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // issue
  // ****
  initial begin
    issue_valid = 1'h0;
    instr = '0;
    {fp_source_a, fp_source_b, source_reg_a, source_reg_b} = '0;
  end
  task automatic issue(input logic [INSN_W-1:0] ins, input logic [XLEN-1:0] fa,
    input logic [XLEN-1:0] fb);
    @(negedge clk_sys);
    issue_valid = 1'h1;
    instr = ins;
    fp_source_a = fa;
    fp_source_b = fb;
    source_reg_a = {{WORD{fa[WORD-1]}}, fa[WORD-1:0]};
    source_reg_b = {{WORD{fb[WORD-1]}}, fb[WORD-1:0]};
    @(negedge clk_sys);
    issue_valid = 1'h0;
    // released lines flip, so a stale value never passes for live data
    instr = ~instr;
    fp_source_a = ~fp_source_a;
    fp_source_b = ~fp_source_b;
    source_reg_a = ~source_reg_a;
    source_reg_b = ~source_reg_b;
  endtask : issue
endmodule : aau_core_model

/* File: testbench/arith_add_abs_unit_tb.sv */
// self-checking bench for the add/abs execution unit
// assumes the core model drives all issue inputs; config is driven here
module arith_add_abs_unit_tb
  import aau_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, issue_valid, done, fpr_we, gpr_we;
  logic clk_en, fpu_usable, fpu_is_64bit, fp_reg_model_bit, release6_cfg;
  logic magnitude2008_capable, nonarith_magnitude_bit;
  logic [1:0] fp_round_mode;
  logic [FLAG_W-1:0] fp_trap_enable, fp_flags;
  logic [INSN_W-1:0] instr;
  logic [XLEN-1:0] fp_source_a, fp_source_b, source_reg_a, source_reg_b, result;
  logic [REG_W-1:0] dest_idx;
  logic [CAUSE_W-1:0] fp_cause;
  aau_exc_t exc_code;
  int errors = 0;
  int num_checks = 0;
  logic [XLEN-1:0] rnd_exp [4] = '{64'h3F800000, 64'h3F800000, 64'h3F800001, 64'h3F800000};
  aau_core_model aau_core_model_inst (.clk_sys, .issue_valid, .instr, .fp_source_a,
    .fp_source_b, .source_reg_a, .source_reg_b);
  aau_unit aau_unit_inst (.clk_sys, .rst, .clk_en, .issue_valid, .instr, .fp_source_a,
    .fp_source_b, .source_reg_a, .source_reg_b, .fpu_usable, .fpu_is_64bit, .fp_reg_model_bit,
    .release6_cfg, .magnitude2008_capable, .nonarith_magnitude_bit, .fp_round_mode,
    .fp_trap_enable, .done, .exc_code, .fpr_we, .gpr_we, .dest_idx, .result, .fp_cause,
    .fp_flags);
  // ****
  // helpers
  // ****
  function automatic logic [INSN_W-1:0] fpi(logic [REG_W-1:0] fmt, logic [OPC_W-1:0] fn,
    logic [REG_W-1:0] ft);
    return {OP_FP, fmt, ft, 5'h02, 5'h03, fn};
  endfunction : fpi
  function automatic logic [INSN_W-1:0] ri(logic [REG_W-1:0] sh);
    return {OP_SPECIAL, 5'h01, 5'h02, 5'h04, sh, FN_TADD};
  endfunction : ri
  function automatic logic [INSN_W-1:0] im(logic [IMM_W-1:0] imm);
    return {OP_TADDI, 5'h01, 5'h05, imm};
  endfunction : im
  task automatic chk(input string n, input logic [XLEN-1:0] e, input logic [XLEN-1:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic st(input logic [CAUSE_W-1:0] c, input logic [FLAG_W-1:0] f);
    chk("fp_cause", c, fp_cause);
    chk("fp_flags", f, fp_flags);
  endtask : st
  // one issue; the answer stands from the taking edge up to the next edge
  task automatic op(input logic [INSN_W-1:0] ins, input logic [XLEN-1:0] fa,
    input logic [XLEN-1:0] fb, input aau_exc_t ex, input logic [XLEN-1:0] res);
    logic isf;
    logic [REG_W-1:0] dst;
    isf = (ins[31:26] == OP_FP);
    dst = isf ? 5'h03 : ((ins[31:26] == OP_TADDI) ? 5'h05 : 5'h04);
    aau_core_model_inst.issue(ins, fa, fb);
    chk("done", 1'h1, done);
    chk("exc_code", ex, exc_code);
    chk("fpr_we", ex == EXC_NONE && isf, fpr_we);
    chk("gpr_we", ex == EXC_NONE && !isf, gpr_we);
    if (ex == EXC_NONE) begin
      chk("result", res, result);
      chk("dest_idx", dst, dest_idx);
    end
    @(negedge clk_sys);
  endtask : op
  task automatic results();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  // ****
  // tests
  // ****
  initial begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #5000;
    errors++;
    results();
  end
  initial begin
    rst = 1'h1;
    clk_en = 1'h1;
    {fpu_usable, fpu_is_64bit, fp_reg_model_bit} = 3'h7;
    {release6_cfg, magnitude2008_capable, nonarith_magnitude_bit} = 3'h0;
    fp_round_mode = RM_RN;
    fp_trap_enable = 5'h00;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'h0;
    chk("done", 1'h0, done);
    st(6'h00, 5'h00);
    op(ri(5'h00), 64'h7FFFFFFE, 64'h1, EXC_NONE, 64'h7FFFFFFF);
    op(ri(5'h00), 64'hFFFFFFFF, 64'hFFFFFFFF, EXC_NONE, 64'hFFFFFFFFFFFFFFFE);
    op(ri(5'h00), 64'h7FFFFFFF, 64'h1, EXC_OVF, 64'h0);
    op(ri(5'h00), 64'h80000000, 64'hFFFFFFFF, EXC_OVF, 64'h0);
    op(ri(5'h01), 64'h1, 64'h1, EXC_RI, 64'h0);
    op(im(16'hFFFF), 64'h5, 64'h0, EXC_NONE, 64'h4);
    op(im(16'h8000), 64'h80000000, 64'h0, EXC_OVF, 64'h0);
    op(fpi(FMT_S, FN_ABS, 5'h00), 64'hBF800000, 64'h0, EXC_NONE, 64'h3F800000);
    st(6'h00, 5'h00);
    op(fpi(FMT_S, FN_ABS, 5'h01), 64'hBF800000, 64'h0, EXC_RI, 64'h0);
    op(fpi(FMT_D, FN_ABS, 5'h00), 64'hC000000000000000, 64'h0, EXC_NONE,
      64'h4000000000000000);
    op(fpi(FMT_S, FN_ABS, 5'h00), 64'hFFC00001, 64'h0, EXC_NONE, 64'h7FC00000);
    st(6'h10, 5'h10);
    nonarith_magnitude_bit = 1'h1;
    op(fpi(FMT_S, FN_ABS, 5'h00), 64'hFFC00001, 64'h0, EXC_NONE, 64'h7FC00000);
    op(fpi(FMT_PS, FN_ABS, 5'h00), 64'hBF800000C0000000, 64'h0, EXC_NONE,
      64'h3F80000040000000);
    op(fpi(FMT_PS, FN_FADD, 5'h04), 64'h3F80000040000000, 64'h3F8000003F800000, EXC_NONE,
      64'h4000000040400000);
    op(fpi(FMT_D, FN_FADD, 5'h04), 64'h3FF0000000000000, 64'h3FF0000000000000, EXC_NONE,
      64'h4000000000000000);
    for (int i = 0; i < 4; i++) begin
      fp_round_mode = 2'(i);
      op(fpi(FMT_S, FN_FADD, 5'h04), 64'h3F800000, 64'h33800000, EXC_NONE,
        rnd_exp[i]);
      st(6'h01, 5'h11);
    end
    fp_round_mode = RM_RN;
    fp_trap_enable = 5'h04;
    op(fpi(FMT_S, FN_FADD, 5'h04), 64'h7F7FFFFF, 64'h7F7FFFFF, EXC_FPE, 64'h0);
    st(6'h05, 5'h11);
    fp_trap_enable = 5'h00;
    op(fpi(FMT_S, FN_FADD, 5'h04), 64'h7F7FFFFF, 64'h7F7FFFFF, EXC_NONE,
      64'h7F800000);
    st(6'h05, 5'h15);
    magnitude2008_capable = 1'h1;
    op(fpi(FMT_S, FN_ABS, 5'h00), 64'hFFC00001, 64'h0, EXC_NONE, 64'h7FC00001);
    st(6'h05, 5'h15);
    op(fpi(FMT_D, FN_ABS, 5'h00), 64'hFFF0000000000001, 64'h0, EXC_NONE,
      64'h7FF0000000000001);
    st(6'h05, 5'h15);
    release6_cfg = 1'h1;
    op(fpi(FMT_PS, FN_ABS, 5'h00), 64'h0, 64'h0, EXC_RI, 64'h0);
    release6_cfg = 1'h0;
    fp_reg_model_bit = 1'h0;
    op(fpi(FMT_PS, FN_FADD, 5'h04), 64'h0, 64'h0, EXC_RI, 64'h0);
    fp_reg_model_bit = 1'h1;
    fpu_is_64bit = 1'h0;
    op(fpi(FMT_PS, FN_ABS, 5'h00), 64'h0, 64'h0, EXC_RI, 64'h0);
    fpu_is_64bit = 1'h1;
    op(fpi(5'h14, FN_FADD, 5'h04), 64'h0, 64'h0, EXC_RI, 64'h0);
    fpu_usable = 1'h0;
    op(fpi(FMT_S, FN_FADD, 5'h04), 64'h0, 64'h0, EXC_CPU, 64'h0);
    fpu_usable = 1'h1;
    clk_en = 1'h0;
    // frozen unit: the issue is ignored and the outputs hold
    aau_core_model_inst.issue(ri(5'h00), 64'h7FFFFFFF, 64'h1);
    chk("done", 1'h0, done);
    chk("exc_code", EXC_NONE, exc_code);
    clk_en = 1'h1;
    results();
  end
endmodule : arith_add_abs_unit_tb
